//--- verilog/cmr_core_regs.sv
// Purpose: exception mask, base priority, control and execution state
// Assumes: core presents one special-register access or event per cycle
// Notes:   read data appear one cycle after sr_rd_i
//
// How it works
// - execution-state reads zero, writes ignored
// - bits 26:25,15:10 hold block or resume
// - interrupted multiple records next index 15:12
// - return resumes multiple from stored index
// - resume state keeps 26:25 and 11:10 zero
// - conditional block at most four instructions
// - priority mask blocks configurable-priority exceptions
// - fault mask blocks all but NMI
// - handler exit except NMI clears fault mask
// - nonzero base refuses equal or lower priority
// - larger priority value means lower priority
// - control bit 1 selects process stack
// - handler mode: main stack, bit reads zero
// - control bit 0 makes thread unprivileged
// - entry and return update control register
// - thread starts main stack, write 1 switches
// - special moves and change-state reach masks
// - every exception except reset in handler
// - stack select is zero after reset
`timescale 1ns/10ps
`default_nettype none
module cmr_core_regs (
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    input  wire logic        sr_rd_i,
    input  wire logic        sr_wr_i,
    input  wire logic [2:0]  sr_sel_i,
    input  wire logic [31:0] sr_wdata_i,
    input  wire logic        chg_i,
    input  wire logic        chg_fault_i,
    input  wire logic        chg_set_i,
    input  wire logic        exc_entry_i,
    input  wire logic        exc_return_i,
    input  wire logic        ret_thread_i,
    input  wire logic        ret_proc_stack_i,
    input  wire logic        ret_from_nmi_i,
    input  wire logic        multi_irq_i,
    input  wire logic [3:0]  multi_next_i,
    input  wire logic        cond_start_i,
    input  wire logic [3:0]  cond_first_i,
    input  wire logic [3:0]  cond_mask_i,
    input  wire logic        cond_step_i,
    input  wire logic        req_valid_i,
    input  wire logic [7:0]  req_prio_i,
    input  wire logic        req_nmi_i,
    input  wire logic        req_fixed_i,
    output logic [31:0]      rdata_o,
    output logic             rvalid_o,
    output logic             exc_accept_o,
    output logic             handler_o,
    output logic             proc_stack_o,
    output logic             thread_unpriv_o,
    output logic [31:0]      exec_state_o,
    output logic             resume_go_o,
    output logic [3:0]       resume_idx_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic              pri;
        logic              flt;
        logic [3:0]        base;
        logic              spsel;
        logic              thread_priv;
        logic              handler;
        cmr_pkg::cmr_exec_t xs;
        logic [7:0]        xbits;
        logic [31:0]       exec_word;
        logic [31:0]       rdata;
        logic              rvalid;
        logic              accept;
        logic              resume_go;
        logic [3:0]        resume_idx;
    } cmr_state_t;

    cmr_state_t s;
    cmr_state_t next_s;
    logic       privileged;

    cmr_gate_if gif ();

    // xbits[7:2] sit at 15:10, xbits[1:0] at 26:25, bit 24 always set
    function automatic logic [31:0] exec_pack(input logic [7:0] x);
        exec_pack = {5'h00, x[1:0], 1'h1, 8'h00, x[7:2], 10'h000};
    endfunction

    function automatic logic [31:0] read_word(input logic [2:0] sel,
                                              input cmr_state_t st);
        read_word = 32'h0000_0000;
        case (sel)
            cmr_pkg::SEL_PRI:  read_word[cmr_pkg::PRI_BIT] = st.pri;
            cmr_pkg::SEL_FLT:  read_word[cmr_pkg::FLT_BIT] = st.flt;
            cmr_pkg::SEL_BASE:
                read_word[cmr_pkg::BASE_MSB:cmr_pkg::BASE_LSB] = st.base;
            cmr_pkg::SEL_CTRL: begin
                read_word[cmr_pkg::CTRL_PRIV] = st.thread_priv;
                read_word[cmr_pkg::CTRL_SPS] = st.spsel & ~st.handler;
            end
            default: read_word = 32'h0000_0000;
        endcase
    endfunction

    // ------------------------------------------------------------
    // gate hookup
    // ------------------------------------------------------------
    assign gif.pri_mask  = s.pri;
    assign gif.flt_mask  = s.flt;
    assign gif.base      = s.base;
    assign gif.req_valid = req_valid_i;
    assign gif.req_prio  = req_prio_i;
    assign gif.req_nmi   = req_nmi_i;
    assign gif.req_fixed = req_fixed_i;

    cmr_gate u_gate (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .g         (gif.gate)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s           = s;
        next_s.rvalid    = 1'b0;
        next_s.resume_go = 1'b0;
        privileged       = s.handler | ~s.thread_priv;

        if (sr_rd_i) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = read_word(sr_sel_i, s);
        end

        if (sr_wr_i && privileged) begin
            case (sr_sel_i)
                cmr_pkg::SEL_PRI:
                    next_s.pri = sr_wdata_i[cmr_pkg::PRI_BIT];
                cmr_pkg::SEL_FLT:
                    next_s.flt = sr_wdata_i[cmr_pkg::FLT_BIT];
                cmr_pkg::SEL_BASE:
                    next_s.base =
                        sr_wdata_i[cmr_pkg::BASE_MSB:cmr_pkg::BASE_LSB];
                cmr_pkg::SEL_CTRL: begin
                    next_s.thread_priv = sr_wdata_i[cmr_pkg::CTRL_PRIV];
                    if (!s.handler) begin
                        next_s.spsel = sr_wdata_i[cmr_pkg::CTRL_SPS];
                    end
                end
                default: next_s.pri = s.pri;
            endcase
        end

        if (chg_i && privileged) begin
            if (chg_fault_i) begin
                next_s.flt = chg_set_i;
            end else begin
                next_s.pri = chg_set_i;
            end
        end

        if (s.xs == cmr_pkg::EX_COND && cond_step_i) begin
            if (s.xbits[2:0] == 3'h0) begin
                next_s.xs    = cmr_pkg::EX_NONE;
                next_s.xbits = cmr_pkg::RST_XBITS;
            end else begin
                next_s.xbits[4:0] = {s.xbits[3:0], 1'b0};
            end
        end
        // zero mask would mean an empty block, so it is refused
        if (cond_start_i && s.xs != cmr_pkg::EX_RESUME &&
            cond_mask_i != 4'h0) begin
            next_s.xs    = cmr_pkg::EX_COND;
            next_s.xbits = {cond_first_i, cond_mask_i};
        end

        if (multi_irq_i) begin
            next_s.xs    = cmr_pkg::EX_RESUME;
            next_s.xbits = {multi_next_i, 4'h0};
        end

        if (exc_entry_i) begin
            next_s.handler = 1'b1;
            next_s.spsel   = 1'b0;
        end

        if (exc_return_i) begin
            next_s.handler = ~ret_thread_i;
            next_s.spsel   = ret_thread_i & ret_proc_stack_i;
            if (!ret_from_nmi_i) begin
                next_s.flt = 1'b0;
            end
            if (s.xs == cmr_pkg::EX_RESUME) begin
                next_s.resume_go  = 1'b1;
                next_s.resume_idx = s.xbits[7:4];
                next_s.xs         = cmr_pkg::EX_NONE;
                next_s.xbits      = cmr_pkg::RST_XBITS;
            end
        end

        next_s.accept    = gif.accept;
        next_s.exec_word = exec_pack(next_s.xbits);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s.pri        <= cmr_pkg::RST_MASK;
            s.flt        <= cmr_pkg::RST_MASK;
            s.base       <= cmr_pkg::RST_BASE;
            s.spsel      <= cmr_pkg::RST_CTRL;
            s.thread_priv <= cmr_pkg::RST_CTRL;
            s.handler    <= 1'b0;
            s.xs         <= cmr_pkg::EX_NONE;
            s.xbits      <= cmr_pkg::RST_XBITS;
            s.exec_word  <= cmr_pkg::RST_EXEC;
            s.rdata      <= 32'h0000_0000;
            s.rvalid     <= 1'b0;
            s.accept     <= 1'b0;
            s.resume_go  <= 1'b0;
            s.resume_idx <= 4'h0;
        end else begin
            s <= next_s;
        end
    end

    assign rdata_o         = s.rdata;
    assign rvalid_o        = s.rvalid;
    assign exc_accept_o    = s.accept;
    assign handler_o       = s.handler;
    assign proc_stack_o    = s.spsel;
    assign thread_unpriv_o = s.thread_priv;
    assign exec_state_o    = s.exec_word;
    assign resume_go_o     = s.resume_go;
    assign resume_idx_o    = s.resume_idx;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_exec_read_zero;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (sr_rd_i && sr_sel_i == 3'h0) |=> (rvalid_o && rdata_o == 32'h0);
    endproperty
    a_exec_read_zero: assert property (p_exec_read_zero)
        else $error("execution state read not zero");

    property p_resume_record;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (multi_irq_i && !exc_return_i) |=>
            (exec_state_o[15:12] == $past(multi_next_i) &&
             exec_state_o[11:10] == 2'h0 && exec_state_o[26:25] == 2'h0);
    endproperty
    a_resume_record: assert property (p_resume_record)
        else $error("resume index not recorded");

    property p_resume_go;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (exc_return_i && s.xs == cmr_pkg::EX_RESUME) |=>
            (resume_go_o && resume_idx_o == $past(exec_state_o[15:12]));
    endproperty
    a_resume_go: assert property (p_resume_go)
        else $error("multiple transfer not resumed");

    property p_fault_clear;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (exc_return_i && !ret_from_nmi_i) |=> !s.flt;
    endproperty
    a_fault_clear: assert property (p_fault_clear)
        else $error("fault mask not cleared on exit");

    property p_entry_handler;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (exc_entry_i && !exc_return_i) |=> (handler_o && !proc_stack_o);
    endproperty
    a_entry_handler: assert property (p_entry_handler)
        else $error("entry did not select handler on main stack");

    property p_handler_spsel;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (handler_o && sr_wr_i && sr_sel_i == 3'h4 && !exc_return_i)
        |=> !proc_stack_o;
    endproperty
    a_handler_spsel: assert property (p_handler_spsel)
        else $error("handler write changed stack select");

    property p_unpriv_write;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (sr_wr_i && !handler_o && thread_unpriv_o && !chg_i &&
         !exc_entry_i && !exc_return_i) |=>
            ($stable(s.pri) && $stable(s.base) &&
             $stable(s.thread_priv) && $stable(s.flt));
    endproperty
    a_unpriv_write: assert property (p_unpriv_write)
        else $error("unprivileged write took effect");

    property p_bit24;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        exec_state_o[24] && (s.xs != cmr_pkg::EX_NONE ||
            (exec_state_o[26:25] == 2'h0 && exec_state_o[15:10] == 6'h0));
    endproperty
    a_bit24: assert property (p_bit24)
        else $error("execution state word wrong when idle");
endmodule // cmr_core_regs
`default_nettype wire

//--- verilog/cmr_pkg.sv
// Purpose: shared constants for the core mask and control registers
// Assumes: one 50 MHz core clock, special-register port driven by the core
// Notes:   selector codes are the block's own encoding of register names
`default_nettype none
package cmr_pkg;
    // ------------------------------------------------------------
    // special-register selectors
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_EXEC = 3'h0;
    localparam logic [2:0] SEL_PRI  = 3'h1;
    localparam logic [2:0] SEL_FLT  = 3'h2;
    localparam logic [2:0] SEL_BASE = 3'h3;
    localparam logic [2:0] SEL_CTRL = 3'h4;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PRI_BIT   = 0;
    localparam int FLT_BIT   = 0;
    localparam int BASE_LSB  = 4;
    localparam int BASE_MSB  = 7;
    localparam int CTRL_PRIV = 0;
    localparam int CTRL_SPS  = 1;
    localparam int EXEC_IDX_LSB = 12;
    localparam int EXEC_IDX_MSB = 15;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic       RST_MASK = 1'b0;
    localparam logic [3:0] RST_BASE = 4'h0;
    localparam logic       RST_CTRL = 1'b0;
    localparam logic [7:0] RST_XBITS = 8'h00;
    // idle word: only the always-set bit 24
    localparam logic [31:0] RST_EXEC = 32'h0100_0000;

    typedef enum logic [1:0] {
        EX_NONE,
        EX_COND,
        EX_RESUME
    } cmr_exec_t;
endpackage
`default_nettype wire

//--- verilog/cmr_gate_if.sv
// Purpose: carries masks and one exception request to the gate
// Assumes: both ends on clk_sys_i
// Notes:   accept is combinational from the gate
`timescale 1ns/10ps
`default_nettype none
interface cmr_gate_if;
    logic       pri_mask;
    logic       flt_mask;
    logic [3:0] base;
    logic       req_valid;
    logic [7:0] req_prio;
    logic       req_nmi;
    logic       req_fixed;
    logic       accept;

    modport ctl  (output pri_mask, output flt_mask, output base,
                  output req_valid, output req_prio, output req_nmi,
                  output req_fixed, input accept);
    modport gate (input pri_mask, input flt_mask, input base,
                  input req_valid, input req_prio, input req_nmi,
                  input req_fixed, output accept);
endinterface
`default_nettype wire

//--- verilog/cmr_gate.sv
// Purpose: decides whether a pending exception may be activated
// Assumes: request fields stable while req_valid is high
// Notes:   fixed-priority requests ignore the priority mask and base
`timescale 1ns/10ps
`default_nettype none
module cmr_gate (
    input  wire logic clk_sys_i,
    input  wire logic rstn_i,
    cmr_gate_if.gate  g
);
    logic base_block;

    always_comb begin
        base_block = (g.base != cmr_pkg::RST_BASE) &&
                     (g.req_prio[cmr_pkg::BASE_MSB:cmr_pkg::BASE_LSB]
                      >= g.base);
        g.accept = g.req_valid;
        if (g.pri_mask && !g.req_fixed) begin
            g.accept = 1'b0;
        end
        if (base_block && !g.req_fixed) begin
            g.accept = 1'b0;
        end
        if (g.flt_mask && !g.req_nmi) begin
            g.accept = 1'b0;
        end
    end

    property p_pri_block;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (g.pri_mask && !g.req_fixed) |-> !g.accept;
    endproperty
    a_pri_block: assert property (p_pri_block)
        else $error("priority mask did not block");

    property p_flt_block;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (g.flt_mask && !g.req_nmi) |-> !g.accept;
    endproperty
    a_flt_block: assert property (p_flt_block)
        else $error("fault mask did not block");

    property p_base_block;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (g.base != 4'h0 && !g.req_fixed && g.req_prio[7:4] >= g.base)
        |-> !g.accept;
    endproperty
    a_base_block: assert property (p_base_block)
        else $error("base priority did not block");
endmodule // cmr_gate
`default_nettype wire

//--- bench/testbench.sv
// Purpose: self-checking bench for the core mask and control registers
// Assumes: registered outputs, one idle cycle between driven operations
// Notes:   read data and gate answers are checked from expectation queues
`timescale 1ns/10ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic       pri;
        logic       flt;
        logic [3:0] base;
        logic [7:0] prio;
        logic       nmi;
        logic       fixed;
        logic       acc;
    } cmr_tb_case_t;

    logic        clk_sys_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        sr_rd_i = 1'b0, sr_wr_i = 1'b0, chg_i = 1'b0;
    logic [2:0]  sr_sel_i = 3'h0;
    logic [31:0] sr_wdata_i = 32'h0;
    logic        chg_fault_i = 1'b0, chg_set_i = 1'b0;
    logic        exc_entry_i = 1'b0, exc_return_i = 1'b0;
    logic        ret_thread_i = 1'b0, ret_proc_stack_i = 1'b0;
    logic        ret_from_nmi_i = 1'b0, multi_irq_i = 1'b0;
    logic [3:0]  multi_next_i = 4'h0, cond_first_i = 4'h0;
    logic [3:0]  cond_mask_i = 4'h0;
    logic        cond_start_i = 1'b0, cond_step_i = 1'b0;
    logic        req_valid_i = 1'b0, req_nmi_i = 1'b0, req_fixed_i = 1'b0;
    logic [7:0]  req_prio_i = 8'h0;
    logic [31:0] rdata_o, exec_state_o;
    logic        rvalid_o, exc_accept_o, handler_o, proc_stack_o;
    logic        thread_unpriv_o, resume_go_o;
    logic [3:0]  resume_idx_o;
    logic        req_d = 1'b0;
    logic [31:0] seed = 32'h0000005c;
    logic [31:0] rd_q[$];
    logic        acc_q[$];
    int          errors = 0;
    int          total_checks = 0;
    cmr_tb_case_t cases [9] = '{
        '{1'b0, 1'b0, 4'h0, 8'h40, 1'b0, 1'b0, 1'b1},
        '{1'b1, 1'b0, 4'h0, 8'h40, 1'b0, 1'b0, 1'b0},
        '{1'b1, 1'b0, 4'h0, 8'h00, 1'b0, 1'b1, 1'b1},
        '{1'b0, 1'b1, 4'h0, 8'h00, 1'b0, 1'b1, 1'b0},
        '{1'b0, 1'b1, 4'h0, 8'h00, 1'b1, 1'b1, 1'b1},
        '{1'b0, 1'b0, 4'h4, 8'h40, 1'b0, 1'b0, 1'b0},
        '{1'b0, 1'b0, 4'h4, 8'h3f, 1'b0, 1'b0, 1'b1},
        '{1'b0, 1'b0, 4'h4, 8'h50, 1'b0, 1'b0, 1'b0},
        '{1'b0, 1'b0, 4'h4, 8'h00, 1'b0, 1'b1, 1'b1}};

    cmr_core_regs u_cmr_core_regs (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sr_rd_i(sr_rd_i),
        .sr_wr_i(sr_wr_i), .sr_sel_i(sr_sel_i), .sr_wdata_i(sr_wdata_i),
        .chg_i(chg_i), .chg_fault_i(chg_fault_i), .chg_set_i(chg_set_i),
        .exc_entry_i(exc_entry_i), .exc_return_i(exc_return_i),
        .ret_thread_i(ret_thread_i), .ret_proc_stack_i(ret_proc_stack_i),
        .ret_from_nmi_i(ret_from_nmi_i), .multi_irq_i(multi_irq_i),
        .multi_next_i(multi_next_i), .cond_start_i(cond_start_i),
        .cond_first_i(cond_first_i), .cond_mask_i(cond_mask_i),
        .cond_step_i(cond_step_i), .req_valid_i(req_valid_i),
        .req_prio_i(req_prio_i), .req_nmi_i(req_nmi_i),
        .req_fixed_i(req_fixed_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .exc_accept_o(exc_accept_o), .handler_o(handler_o),
        .proc_stack_o(proc_stack_o), .thread_unpriv_o(thread_unpriv_o),
        .exec_state_o(exec_state_o), .resume_go_o(resume_go_o),
        .resume_idx_o(resume_idx_o));

    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    // ------------------------------------------------------------
    // comparison, verdict, random source
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results;
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // ------------------------------------------------------------
    // operations: set at one falling edge, clear at the next
    // ------------------------------------------------------------
    task automatic op_end;
        @(negedge clk_sys_i);
        {sr_rd_i, sr_wr_i, chg_i, exc_entry_i, exc_return_i} = 5'h0;
        {multi_irq_i, cond_start_i, cond_step_i, req_valid_i} = 4'h0;
    endtask

    task automatic rd(input logic [2:0] s, input logic [31:0] e);
        @(negedge clk_sys_i);
        sr_sel_i = s;
        sr_rd_i = 1'b1;
        rd_q.push_back(e);
        op_end();
    endtask

    task automatic wr(input logic [2:0] s, input logic [31:0] d);
        @(negedge clk_sys_i);
        sr_sel_i = s;
        sr_wdata_i = d;
        sr_wr_i = 1'b1;
        op_end();
    endtask

    task automatic chg_state(input logic f, input logic v);
        @(negedge clk_sys_i);
        chg_fault_i = f;
        chg_set_i = v;
        chg_i = 1'b1;
        op_end();
    endtask

    task automatic entry;
        @(negedge clk_sys_i);
        exc_entry_i = 1'b1;
        op_end();
    endtask

    task automatic ret(input logic t, input logic p, input logic n);
        @(negedge clk_sys_i);
        {ret_thread_i, ret_proc_stack_i, ret_from_nmi_i} = {t, p, n};
        exc_return_i = 1'b1;
        op_end();
    endtask

    task automatic step;
        @(negedge clk_sys_i);
        cond_step_i = 1'b1;
        op_end();
    endtask

    // ------------------------------------------------------------
    // result watcher: oldest note against each answer
    // ------------------------------------------------------------
    always @(posedge clk_sys_i) req_d <= req_valid_i;

    always @(negedge clk_sys_i) begin
        if (rvalid_o === 1'b1) begin
            if (rd_q.size() == 0) begin
                check(rdata_o, 32'hffffffff);
            end else begin
                check(rdata_o, rd_q.pop_front());
            end
        end
        if (req_d && acc_q.size() > 0) begin
            check(32'(exc_accept_o), 32'(acc_q.pop_front()));
        end
    end

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        errors++;
        results();
    end

    initial begin
        logic [31:0] d;
        logic [3:0]  n;
        repeat (5) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        // ------------------------------------------------------------
        // reset values and plain register access
        // ------------------------------------------------------------
        check(exec_state_o, 32'h01000000);
        check(32'(proc_stack_o), 32'h0);
        for (int s = 0; s < 6; s++) rd(3'(s), 32'h0);
        repeat (4) begin
            d = rnd();
            wr(3'h1, d);
            rd(3'h1, d & 32'h1);
            wr(3'h3, d);
            rd(3'h3, d & 32'hf0);
            wr(3'h0, d);
            rd(3'h0, 32'h0);
            wr(3'h5, d);
            rd(3'h5, 32'h0);
        end
        // ------------------------------------------------------------
        // activation gating
        // ------------------------------------------------------------
        foreach (cases[i]) begin
            chg_state(1'b0, cases[i].pri);
            chg_state(1'b1, cases[i].flt);
            wr(3'h3, {24'h0, cases[i].base, 4'h0});
            rd(3'h1, 32'(cases[i].pri));
            @(negedge clk_sys_i);
            {req_prio_i, req_nmi_i, req_fixed_i} =
                {cases[i].prio, cases[i].nmi, cases[i].fixed};
            req_valid_i = 1'b1;
            acc_q.push_back(cases[i].acc);
            op_end();
        end
        chg_state(1'b1, 1'b0);
        wr(3'h3, 32'h0);
        // ------------------------------------------------------------
        // stack selection across exceptions
        // ------------------------------------------------------------
        // thread-mode write of control bit 1 selects process stack
        wr(3'h4, 32'h2);
        check(32'(proc_stack_o), 32'h1);
        rd(3'h4, 32'h2);
        entry();
        check(32'({handler_o, proc_stack_o}), 32'h2);
        rd(3'h4, 32'h0);
        wr(3'h4, 32'h2);
        rd(3'h4, 32'h0);
        chg_state(1'b1, 1'b1);
        ret(1'b1, 1'b1, 1'b0);
        check(32'({handler_o, proc_stack_o}), 32'h1);
        rd(3'h2, 32'h0);
        @(negedge clk_sys_i);
        rstn_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        check(32'(proc_stack_o), 32'h0);
        entry();
        chg_state(1'b1, 1'b1);
        ret(1'b1, 1'b0, 1'b1);
        rd(3'h2, 32'h1);
        check(32'(proc_stack_o), 32'h0);
        chg_state(1'b1, 1'b0);
        // ------------------------------------------------------------
        // unprivileged thread
        // ------------------------------------------------------------
        wr(3'h4, 32'h1);
        check(32'(thread_unpriv_o), 32'h1);
        wr(3'h1, 32'h1);
        rd(3'h1, 32'h0);
        wr(3'h4, 32'h0);
        check(32'(thread_unpriv_o), 32'h1);
        entry();
        wr(3'h4, 32'h0);
        ret(1'b1, 1'b0, 1'b0);
        check(32'(thread_unpriv_o), 32'h0);
        // ------------------------------------------------------------
        // interrupted multiple transfer
        // ------------------------------------------------------------
        n = 4'(rnd());
        @(negedge clk_sys_i);
        multi_next_i = n;
        multi_irq_i = 1'b1;
        op_end();
        check(32'(exec_state_o[15:12]), 32'(n));
        check(exec_state_o & 32'h07000c00, 32'h01000000);
        @(negedge clk_sys_i);
        {cond_first_i, cond_mask_i} = 8'h5f;
        cond_start_i = 1'b1;
        op_end();
        check(32'(exec_state_o[15:10]), 32'({n, 2'h0}));
        rd(3'h0, 32'h0);
        entry();
        ret(1'b1, 1'b0, 1'b0);
        check(32'({resume_go_o, resume_idx_o}), 32'({1'b1, n}));
        check(exec_state_o, 32'h01000000);
        // ------------------------------------------------------------
        // four-instruction conditional block
        // ------------------------------------------------------------
        @(negedge clk_sys_i);
        {cond_first_i, cond_mask_i} = 8'ha1;
        cond_start_i = 1'b1;
        op_end();
        check(32'(|(exec_state_o & 32'h0600fc00)), 32'h1);
        repeat (3) step();
        check(32'(|(exec_state_o & 32'h0600fc00)), 32'h1);
        step();
        check(exec_state_o, 32'h01000000);
        for (int k = 0; k < 10 && rd_q.size() > 0; k++) begin
            @(negedge clk_sys_i);
        end
        if (rd_q.size() != 0 || acc_q.size() != 0) errors++;
        results();
    end
endmodule // testbench
`default_nettype wire
